// File: shared/dpram_host_regs.svh
// register offsets, fields and timing counts of the dual-port ram port controller
`ifndef DPRAM_HOST_REGS_SVH
`define DPRAM_HOST_REGS_SVH

// ==================================================================
// register word offsets on the avalon slave
`define REG_CMD          4'h0
`define REG_ADDR         4'h1
`define REG_WDATA        4'h2
`define REG_RDATA        4'h3
`define REG_STATUS       4'h4
`define REG_CFG          4'h5

// ==================================================================
// command field encodings (write data bits 1:0 of the command register)
`define CMD_RAM_READ     2'h0
`define CMD_RAM_WRITE    2'h1
`define CMD_SEM_CLAIM    2'h2
`define CMD_SEM_RELEASE  2'h3

// ==================================================================
// status bits
`define ST_BUSY_BIT      0
`define ST_BUSY_SEEN_BIT 1
`define ST_SEM_GOT_BIT   2
`define ST_MAILBOX_BIT   3

// ==================================================================
// device facts
`define MBOX_LEFT_ADDR   13'h1ffe
`define MBOX_RIGHT_ADDR  13'h1fff
`define SEM_INDEX_BITS   3

// ==================================================================
// timing in ns and derived cycle counts at 20 mhz (50 ns)
`define CLK_PERIOD_NS    50
`define T_SETUP_NS       50
`define T_STROBE_NS      100
`define T_HOLD_NS        50
`define T_SEM_WR_RD_NS   50
`define CYC_SETUP   ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_STROBE  ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_HOLD    ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SEM_GAP ((`T_SEM_WR_RD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: shared/dpram_host_pkg.sv
// types of the dual-port ram port controller
package dpram_host_pkg;

   typedef struct packed
   {
      logic        ce_n;
      logic        token_latch_select_n;
      logic        we_n;
      logic        oe_n;
      logic [12:0] addr;
   } port_ctrl_t;

   typedef struct packed
   {
      logic [7:0] dout;
      logic       dout_en;
   } port_data_t;

   typedef enum logic [5:0]
   {
      st_idle   = 6'b000001,
      st_setup  = 6'b000010,
      st_strobe = 6'b000100,
      st_hold   = 6'b001000,
      st_gap    = 6'b010000,
      st_done   = 6'b100000
   } phase_t;

endpackage

// File: design/dpram_port_host.sv
// controller that drives one port of an asynchronous dual-port ram from avalon registers
// Operation
// - write starts when both low; first to rise ends it
// - write strobe stays high whenever address lines change
// - write strobe stays high for the whole read cycle
// - address is valid before or with chip enable falling
// - semaphore write-then-read keeps chip enable high throughout
// - writing a low with token select active and chip enable high claims
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`include "dpram_host_regs.svh"

module dpram_port_host
#(
   parameter bit IS_RIGHT = 1'b0
)
(
   // clock and reset
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_rst,
   // avalon-mm slave
   input  wire logic [3:0]               i_avs_address,
   input  wire logic                     i_avs_read,
   input  wire logic                     i_avs_write,
   input  wire logic [31:0]              i_avs_writedata,
   output logic      [31:0]              o_avs_readdata,
   output logic                          o_avs_waitrequest,
   // device port pins
   output dpram_host_pkg::port_ctrl_t    o_port,
   output dpram_host_pkg::port_data_t    o_data,
   input  wire logic [7:0]               i_data,
   input  wire logic                     i_busy_n,
   input  wire logic                     i_mbox_int_n
);
   import dpram_host_pkg::*;

   // ==================================================================
   // registers
   phase_t      phase;
   logic [1:0]  cmd;
   logic [12:0] addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        busy_seen;
   logic        sem_got;
   logic        active;
   logic [2:0]  cnt;

   // ==================================================================
   // decoding
   wire         is_sem      = cmd[1];
   wire         is_write    = (cmd != `CMD_RAM_READ);
   wire         cnt_zero    = (cnt == 3'h0);
   wire         sel_cmd     = (i_avs_address == `REG_CMD);
   wire         sel_addr    = (i_avs_address == `REG_ADDR);
   wire         sel_wdata   = (i_avs_address == `REG_WDATA);
   wire         wr_ok       = i_avs_write && !active;
   wire         start       = wr_ok && sel_cmd;
   wire [12:0]  own_mbox    = IS_RIGHT ? `MBOX_RIGHT_ADDR : `MBOX_LEFT_ADDR;
   // semaphores sit at index in the low address bits
   wire [12:0]  bus_addr    = is_sem ? {10'h0, addr[`SEM_INDEX_BITS-1:0]} : addr;
   // claim writes a low, release writes a high on data bit 0
   wire [7:0]   bus_wdata   = is_sem ? {7'h0, (cmd == `CMD_SEM_RELEASE)} : wdata;
   wire [7:0]   status      = {4'h0, !i_mbox_int_n, sem_got, busy_seen, !i_busy_n};
   wire         sel_strobe  = (phase == st_strobe);
   // select waits one setup cycle so the address settles first
   wire         sel_on      = (phase == st_setup && cnt_zero) || sel_strobe ||
                              (phase == st_hold) || (phase == st_gap && is_sem);
   // the command lands as the sequencer starts, so the address is reloaded once then
   wire         addr_load   = (phase == st_idle) || (phase == st_setup && !cnt_zero);

   logic [31:0] next_readdata;
   always_comb
   begin
      case (i_avs_address)
         `REG_CMD:    next_readdata = {31'h0, active};
         `REG_ADDR:   next_readdata = {19'h0, addr};
         `REG_WDATA:  next_readdata = {24'h0, wdata};
         `REG_RDATA:  next_readdata = {24'h0, rdata};
         `REG_STATUS: next_readdata = {24'h0, status};
         `REG_CFG:    next_readdata = {19'h0, own_mbox};
         default:     next_readdata = 32'h0;
      endcase
   end

   // ==================================================================
   // avalon answer: one wait cycle, then data; writes to busy core wait
   logic ack;
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         ack            <= 1'b0;
         o_avs_readdata <= 32'h0;
      end
      else
      begin
         ack            <= (i_avs_read || (i_avs_write && !active)) && !ack;
         o_avs_readdata <= next_readdata;
      end
   end
   assign o_avs_waitrequest = !ack;

   // ==================================================================
   // register writes
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         addr  <= 13'h0;
         wdata <= 8'h0;
         cmd   <= `CMD_RAM_READ;
      end
      else if (wr_ok && ack)
      begin
         if (sel_addr)
            addr  <= i_avs_writedata[12:0];
         if (sel_wdata)
            wdata <= i_avs_writedata[7:0];
         if (sel_cmd)
            cmd   <= i_avs_writedata[1:0];
      end
   end

   // ==================================================================
   // access sequencer
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         phase     <= st_idle;
         cnt       <= 3'h0;
         active    <= 1'b0;
         rdata     <= 8'h0;
         busy_seen <= 1'b0;
         sem_got   <= 1'b0;
      end
      else
      begin
         case (phase)
            st_idle:
               if (start && ack)
               begin
                  active <= 1'b1;
                  phase  <= st_setup;
                  cnt    <= 3'(`CYC_SETUP);
               end
            st_setup:
               if (cnt_zero)
               begin
                  phase <= st_strobe;
                  cnt   <= 3'(`CYC_STROBE);
               end
               else
                  cnt <= cnt - 3'h1;
            st_strobe:
            begin
               if (!i_busy_n)
                  busy_seen <= 1'b1;
               if (cnt_zero)
               begin
                  if (!is_write)
                     rdata <= i_data;
                  phase <= st_hold;
                  cnt   <= 3'(`CYC_HOLD);
               end
               else
                  cnt <= cnt - 3'h1;
            end
            st_hold:
               if (cnt_zero)
               begin
                  phase <= is_sem ? st_gap : st_done;
                  cnt   <= 3'(`CYC_SEM_GAP);
               end
               else
                  cnt <= cnt - 3'h1;
            // read back the latch after the write to learn ownership
            st_gap:
               if (cnt_zero)
               begin
                  sem_got <= (cmd == `CMD_SEM_CLAIM) && !i_data[0];
                  rdata   <= i_data;
                  phase   <= st_done;
               end
               else
                  cnt <= cnt - 3'h1;
            st_done:
            begin
               active <= 1'b0;
               phase  <= st_idle;
            end
            default:
               phase <= st_idle;
         endcase
      end
   end

   // ==================================================================
   // pin drive, all registered
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_port  <= '{ce_n: 1'b1, token_latch_select_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                      addr: 13'h0};
         o_data  <= '{dout: 8'h0, dout_en: 1'b0};
      end
      else
      begin
         // address moves only before select, strobe high
         if (addr_load)
            o_port.addr <= bus_addr;
         // chip enable for ram, token select for semaphores
         // chip enable stays high across semaphore write and read
         o_port.ce_n                 <= !(sel_on && !is_sem);
         // semaphore access with chip enable high
         o_port.token_latch_select_n <= !(sel_on && is_sem);
         // strobe low only inside the selected window
         o_port.we_n <= !(is_write && sel_strobe && cnt != 3'h0);
         o_port.oe_n <= !((!is_write && (sel_strobe || phase == st_hold)) ||
                          (is_sem && phase == st_gap));
         // data held through the strobe rise and the hold phase
         o_data.dout    <= bus_wdata;
         o_data.dout_en <= is_write && (sel_strobe || phase == st_hold);
      end
   end

endmodule

// File: tb/dpram_port_host_asserts.sv
// pin-order and handshake checks on the ram port controller
module dpram_port_host_asserts
(
   input wire logic                       i_clk_sys,
   input wire logic                       i_rst,
   input wire logic                       i_avs_read,
   input wire logic                       i_avs_write,
   input wire logic                       o_avs_waitrequest,
   input wire dpram_host_pkg::port_ctrl_t o_port,
   input wire dpram_host_pkg::port_data_t o_data
);
   import dpram_host_pkg::*;
   // ==================================================================
   // properties
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   ack_one_cycle_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("ack longer than one cycle");
   ack_has_req_a: assert property (!o_avs_waitrequest |-> i_avs_read || i_avs_write)
      else $error("ack without request");
   strobe_width_a: assert property ($fell(o_port.we_n) |-> ##1 !o_port.we_n ##1 o_port.we_n)
      else $error("write strobe width");
   write_selected_a: assert property (!o_port.we_n |->
      !o_port.ce_n || !o_port.token_latch_select_n)
      else $error("strobe without select");
   we_ends_first_a: assert property ($rose(o_port.we_n) |->
      !o_port.ce_n || !o_port.token_latch_select_n)
      else $error("select rose before strobe");
   data_hold_a: assert property ($rose(o_port.we_n) |->
      o_data.dout_en && $stable(o_data.dout))
      else $error("data not held at write end");
   addr_quiet_a: assert property (!$stable(o_port.addr) |->
      o_port.we_n && $past(o_port.we_n))
      else $error("address moved in write");
   read_we_high_a: assert property (!o_port.oe_n |-> o_port.we_n && !o_data.dout_en)
      else $error("strobe or drive in read");
   addr_held_a: assert property (!o_port.ce_n && $past(!o_port.ce_n) |->
      $stable(o_port.addr))
      else $error("address moved while selected");
   token_no_ce_a: assert property (!o_port.token_latch_select_n |-> o_port.ce_n)
      else $error("both selects low");
endmodule

bind dpram_port_host dpram_port_host_asserts i_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest), .o_port(o_port), .o_data(o_data));

// File: tb/dpram_device_model.sv
// behavioural model of one ram port with token latches and mailbox flag
module dpram_device_model
(
   input  wire dpram_host_pkg::port_ctrl_t i_port,
   input  wire dpram_host_pkg::port_data_t i_drv,
   input  wire logic                       i_raise,
   input  wire logic [7:0]                 i_other_sem,
   output logic      [7:0]                 o_q,
   output logic                            o_int_n
);
   timeunit 1ns;
   timeprecision 1ns;
   import dpram_host_pkg::*;
   logic [7:0] mem [0:8191];
   logic [7:0] held = 8'h00;
   logic [7:0] last = 8'h5a;
   logic       flag = 1'b0;
   logic       sem_wr;
   wire  [2:0] idx = i_port.addr[2:0];
   wire        sel = !i_port.ce_n || !i_port.token_latch_select_n;
   wire        wr_on = sel && !i_port.we_n;
   wire        rd_on = sel && i_port.we_n && !i_port.oe_n;
   wire  [7:0] val = i_port.token_latch_select_n ? mem[i_port.addr] : {8{!held[idx]}};
   always @(posedge wr_on)
      sem_wr = !i_port.token_latch_select_n;
   always @(negedge wr_on)
      if (sem_wr)
         held[idx] = !i_drv.dout[0] && (held[idx] || !i_other_sem[idx]);
      else
         mem[i_port.addr] = i_drv.dout;
   // pins float outside reads, so show a changed value
   assign o_q = rd_on ? val : ~last;
   always @(negedge rd_on)
      last = val;
   // flag raised by the far port, cleared by our mailbox read
   always @(posedge i_raise)
      flag = 1'b1;
   always @(posedge rd_on)
      if (!i_port.ce_n && i_port.addr == 13'h1ffe)
         flag = 1'b0;
   assign o_int_n = !flag;
endmodule

// File: tb/dual_port_ram_access_arbiter_test.sv
// self-checking bench of the ram port controller against the device model
`include "dpram_host_regs.svh"
module dual_port_ram_access_arbiter_test;
   timeunit 1ns;
   timeprecision 1ns;
   import dpram_host_pkg::*;
   logic        i_clk_sys = 1'b0;
   logic        i_rst = 1'b1;
   logic [3:0]  i_avs_address = 4'h0;
   logic        i_avs_read = 1'b0;
   logic        i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [31:0] o_avs_readdata;
   logic        o_avs_waitrequest;
   port_ctrl_t  o_port;
   port_data_t  o_data;
   logic [7:0]  dev_q;
   logic        i_busy_n = 1'b1;
   logic        i_mbox_int_n;
   logic        raise = 1'b0;
   logic [7:0]  other_sem = 8'h00;
   logic [63:0] exp_q[$];
   logic [63:0] note;
   logic [31:0] rdv;
   int          n_mismatch = 0;
   int          n_tests = 0;
   wire  [7:0]  i_data = o_data.dout_en ? o_data.dout : dev_q;

   always #25 i_clk_sys = ~i_clk_sys;
   dpram_port_host #(.IS_RIGHT(1'b0)) i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .o_port(o_port), .o_data(o_data),
      .i_data(i_data), .i_busy_n(i_busy_n), .i_mbox_int_n(i_mbox_int_n));
   dpram_device_model i_dev (.i_port(o_port), .i_drv(o_data), .i_raise(raise),
      .i_other_sem(other_sem), .o_q(dev_q), .o_int_n(i_mbox_int_n));

   task automatic print_verdict();
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ==================================================================
   // avalon master: hold until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      do
      begin
         @(posedge i_clk_sys);
         n++;
      end
      while (o_avs_waitrequest !== 1'b0 && n < 400);
      rdv = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      if (n >= 400)
      begin
         n_mismatch++;
         print_verdict();
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      exp_q.push_back({m, e});
      bus(1'b0, a, 32'h0);
   endtask
   // start a port access and poll until it is over
   task automatic run(input logic [1:0] c);
      int k;
      bus(1'b1, `REG_CMD, {30'h0, c});
      k = 0;
      do
      begin
         rd(`REG_CMD, 32'h0, 32'h0);
         k++;
      end
      while (rdv[0] !== 1'b0 && k < 50);
      if (k >= 50)
      begin
         n_mismatch++;
         print_verdict();
      end
   endtask
   // ==================================================================
   // result watcher
   always @(posedge i_clk_sys)
      if (i_avs_read && o_avs_waitrequest === 1'b0)
      begin
         note = exp_q.pop_front();
         if (note[63:32] != 32'h0)
            n_tests++;
         if ((o_avs_readdata & note[63:32]) !== note[31:0])
         begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, note[31:0], o_avs_readdata);
         end
      end
   // ==================================================================
   // scenarios
   initial
   begin
      logic [12:0] a;
      logic [7:0]  d;
      logic [2:0]  s;
      void'($urandom(99));
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd(`REG_CFG, 32'h1fff, 32'h1ffe);
      rd(4'h7, 32'hffffffff, 32'h0);
      repeat (4)
      begin
         a = 13'($urandom) & 13'h0fff;
         d = 8'($urandom);
         bus(1'b1, `REG_ADDR, {19'h0, a});
         bus(1'b1, `REG_WDATA, {24'h0, d});
         run(`CMD_RAM_WRITE);
         run(`CMD_RAM_READ);
         rd(`REG_RDATA, 32'hff, {24'h0, d});
      end
      s = 3'($urandom);
      bus(1'b1, `REG_ADDR, {29'h0, s});
      run(`CMD_SEM_CLAIM);
      rd(`REG_STATUS, 32'h4, 32'h4);
      run(`CMD_SEM_RELEASE);
      other_sem[s] <= 1'b1;
      run(`CMD_SEM_CLAIM);
      rd(`REG_STATUS, 32'h4, 32'h0);
      other_sem[s] <= 1'b0;
      run(`CMD_SEM_CLAIM);
      rd(`REG_STATUS, 32'h4, 32'h4);
      raise <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      rd(`REG_STATUS, 32'h8, 32'h8);
      raise <= 1'b0;
      bus(1'b1, `REG_ADDR, {19'h0, `MBOX_LEFT_ADDR});
      run(`CMD_RAM_READ);
      repeat (4) @(posedge i_clk_sys);
      rd(`REG_STATUS, 32'h8, 32'h0);
      // busy held through a read access shows in both status bits, and busy_seen stays set after busy is released
      i_busy_n <= 1'b0;
      run(`CMD_RAM_READ);
      rd(`REG_STATUS, 32'h3, 32'h3);
      i_busy_n <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      rd(`REG_STATUS, 32'h3, 32'h2);
      print_verdict();
   end
endmodule
